//--- analog_output_scaler_tb.sv
// Purpose: Self-checking bench for the analog output scaler
// Assumes: One wait state per bus access, refresh under 200 cycles
// Notes: Table rows first, then count, latch and inversion cases
`timescale 1ns/1ps
module analog_output_scaler_tb;
    import aos_pkg::*;
    typedef struct {bit cur; bit vel; int lo; int hi; int alo; int ahi; int x;} aos_row_t;
    logic clk_sys, rst, clkEn, latchLine, invertLine, freezeReq, invertReq, readOk;
    aos_avs_req_t avsReq;
    logic [31:0] avsReadData, q;
    logic avsWaitRequest;
    logic signed [31:0] position, velocity;
    aos_pol_t latchPol;
    aos_dac_t [AOS_N_OUT-1:0] dacOut;
    int n_mismatch, compares, cyc, e0, e1, n;
    aos_row_t rows [8] = '{'{0, 0, 0, 20, -10000, 10000, 10}, '{0, 0, 0, 20, -10000, 10000, -5},
        '{0, 0, 0, 20, -10000, 10000, 30}, '{1, 1, 0, 100, 4000, 20000, 50}, '{0, 0, 0, 20, 0, 10, 10},
        '{0, 1, 7, 7, -5000, 5000, 7}, '{0, 1, 7, 7, -5000, 5000, 6},
        '{0, 0, 0, 2000000000, -10000, 10000, 1000000000}};
    logic [1:0] pols [3] = '{2'h1, 2'h2, 2'h0};
    logic [2:0] invTab [4] = '{3'b011, 3'b100, 3'b101, 3'b001};
    logic [1:0] cntExp [4] = '{2'h0, 2'h1, 2'h3, 2'h3};

    aos_scaler #(.REFRESH_CYC(200)) i_dut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .avsReq(avsReq),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .position(position),
        .velocity(velocity), .latchLine(latchLine), .invertLine(invertLine), .dacOut(dacOut));
    aos_user_model i_user (.clk_sys(clk_sys), .rst(rst), .freezeReq(freezeReq), .invertReq(invertReq),
        .latchPol(latchPol), .latchLine(latchLine), .invertLine(invertLine), .readOk(readOk));

    always #5 clk_sys = ~clk_sys;

    function automatic int lim(bit cur, int v);
        int t;
        t = v + (cur ? 0 : 10000);
        t = (t < 0) ? 0 : (t > 20000) ? 20000 : t;
        return (t * 16383) / 20000;
    endfunction : lim

    function automatic int expc(bit cur, int lo, int hi, int alo, int ahi, int x);
        int cl, ch;
        cl = lim(cur, alo);
        ch = lim(cur, ahi);
        if (x >= hi) begin
            return ch;
        end
        if (x <= lo) begin
            return cl;
        end
        return cl + int'((longint'(x - lo) * (ch - cl)) / (hi - lo));
    endfunction : expc

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        avsReq.read <= !wr;
        avsReq.write <= wr;
        avsReq.address <= a;
        avsReq.writedata <= d;
        avsReq.byteenable <= 4'hf;
        @(posedge clk_sys);
        while (avsWaitRequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        r = avsReadData;
        avsReq.read <= 1'b0;
        avsReq.write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    task automatic ctrl(input logic [1:0] c, input logic [1:0] lp, input logic [1:0] ip);
        bus(1'b1, AOS_REG_CTRL, {26'h0, ip, lp, c}, q);
    endtask : ctrl

    task automatic cfg(input int ch, input aos_row_t r);
        logic [7:0] b;
        b = 8'(8'h10 + 8'h10 * ch);
        bus(1'b1, b | AOS_CH_CFG, {30'h0, r.vel, r.cur}, q);
        bus(1'b1, b | AOS_CH_INLO, r.lo, q);
        bus(1'b1, b | AOS_CH_INHI, r.hi, q);
        bus(1'b1, b | AOS_CH_ANLIM, {r.ahi[15:0], r.alo[15:0]}, q);
    endtask : cfg

    task automatic test_done;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            test_done;
        end
    end

    initial begin
        clk_sys = 0;
        rst = 1;
        clkEn = 1;
        avsReq = '0;
        position = 0;
        velocity = 0;
        freezeReq = 0;
        invertReq = 0;
        latchPol = AOS_POL_NEVER;
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        chk({dacOut[1].enable, dacOut[0].enable}, 0); // outputs off after reset
        bus(1'b0, AOS_REG_CTRL, 0, q);
        chk(q, 0); // zero count
        foreach (rows[i]) begin
            ctrl(2'h1, 2'h0, 2'h0);
            cfg(0, rows[i]);
            position <= rows[i].vel ? -rows[i].x - 99 : rows[i].x;
            velocity <= rows[i].vel ? rows[i].x : -rows[i].x - 99;
            repeat (200) @(posedge clk_sys);
            e0 = expc(rows[i].cur, rows[i].lo, rows[i].hi, rows[i].alo, rows[i].ahi, rows[i].x);
            chk(dacOut[0].code, e0); // scaled code
            chk(dacOut[0].currentMode, rows[i].cur); // output kind
            bus(1'b0, AOS_REG_CODE0, 0, q);
            chk(q, e0); // code readback
        end
        for (int c = 0; c < 4; c++) begin
            ctrl(2'(c), 2'h0, 2'h0);
            chk({dacOut[1].enable, dacOut[0].enable}, cntExp[c]); // active count
        end
        bus(1'b1, 8'h40, 32'h1234, q);
        bus(1'b0, 8'h40, 0, q);
        chk(q, 0); // unmapped reads zero
        cfg(0, '{0, 0, 0, 1000, -10000, 10000, 0});
        cfg(1, '{1, 0, 0, 1000, 0, 20000, 0});
        foreach (pols[i]) begin
            ctrl(2'h1, pols[i], 2'h0);
            latchPol <= aos_pol_t'(pols[i]);
            position <= 100;
            repeat (200) @(posedge clk_sys);
            freezeReq <= 1'b1;
            n = 0;
            while (readOk !== 1'b1 && n < 3000) begin
                @(posedge clk_sys);
                n++;
            end
            bus(1'b0, AOS_REG_STATUS, 0, q);
            chk(q[0], pols[i] != 2'h0); // frozen in time
            position <= 900;
            repeat (200) @(posedge clk_sys);
            e0 = expc(0, 0, 1000, -10000, 10000, (pols[i] != 2'h0) ? 100 : 900);
            chk(dacOut[0].code, e0); // code held
            freezeReq <= 1'b0;
            repeat (200) @(posedge clk_sys);
            chk(dacOut[0].code, expc(0, 0, 1000, -10000, 10000, 900)); // refresh resumes
        end
        position <= 250;
        e0 = expc(0, 0, 1000, -10000, 10000, 250);
        e1 = expc(1, 0, 1000, 0, 20000, 250);
        foreach (invTab[i]) begin
            ctrl(2'h2, 2'h0, invTab[i][2:1]);
            invertReq <= invTab[i][0];
            repeat (200) @(posedge clk_sys);
            chk(dacOut[0].code, (invTab[i] inside {3'b011, 3'b100}) ? 16383 - e0 : e0); // invert
            chk(dacOut[1].code, e1); // current never inverted
            bus(1'b0, AOS_REG_STATUS, 0, q);
            chk(q[1], invTab[i] inside {3'b011, 3'b100}); // inversion status
        end
        chk(dacOut[1].currentMode, 1'b1); // second output current
        bus(1'b0, AOS_REG_CODE1, 0, q);
        chk(q, e1); // code readback
        // Clock enable low holds all state
        clkEn <= 1'b0;
        position <= 900;
        repeat (200) @(posedge clk_sys);
        chk(dacOut[0].code, e0); // state held
        clkEn <= 1'b1;
        repeat (200) @(posedge clk_sys);
        chk(dacOut[0].code, expc(0, 0, 1000, -10000, 10000, 900)); // conversion resumes
        // Mid-run reset
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({dacOut[1].enable, dacOut[0].enable}, 0); // outputs off again
        chk(dacOut[0].code, 0); // code cleared
        bus(1'b0, AOS_REG_CTRL, 0, q);
        chk(q, 0); // polarities back to never
        test_done;
    end
endmodule : analog_output_scaler_tb

//--- aos_divider.sv
// Purpose: Serial restoring divider for the scaler
// Assumes: den nonzero when started
// Notes: done pulses AOS_NUM_W+1 cycles after start
`timescale 1ns/1ps
module aos_divider (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    // Request
    input wire logic start,
    input wire logic [aos_pkg::AOS_NUM_W-1:0] num,
    input wire logic [aos_pkg::AOS_DEN_W-1:0] den,
    // Answer
    output logic done,
    output logic [aos_pkg::AOS_NUM_W-1:0] quot
);
    import aos_pkg::*;

    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
        logic [AOS_DEN_W:0] rem;
        logic [AOS_NUM_W-1:0] q;
        logic [AOS_DEN_W-1:0] d;
    } aos_div_st_t;

    aos_div_st_t st_r;
    aos_div_st_t st_nxt;

    always_comb begin
        logic [AOS_DEN_W:0] r;
        logic qb;
        r = '0;
        qb = 1'b0;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (start) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = 6'h00;
            st_nxt.rem = '0;
            st_nxt.q = num;
            st_nxt.d = den;
        end else if (st_r.busy) begin
            r = {st_r.rem[AOS_DEN_W-1:0], st_r.q[AOS_NUM_W-1]};
            qb = (r >= {1'b0, st_r.d});
            if (qb) begin
                r = r - {1'b0, st_r.d};
            end
            st_nxt.rem = r;
            st_nxt.q = {st_r.q[AOS_NUM_W-2:0], qb};
            st_nxt.cnt = st_r.cnt + 6'h01;
            if (st_r.cnt == 6'(AOS_NUM_W - 1)) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;
    assign quot = st_r.q;
endmodule : aos_divider

//--- aos_pkg.sv
// Purpose: Shared constants and types for the analog output scaler
// Assumes: 100 MHz clk_sys, Avalon-MM register access
// Notes: Limits in mV (voltage) or uA (current)
// Functional notes
// - Output count selects outputs; zero disables all
// - Each output voltage bipolar or current unipolar
// - Each output follows position or velocity
// - Linear mapping between programmed input limits
// - Outside range, hold matching analog limit
// - 14-bit code spans full 20 V/20 mA
// - Usable steps shrink with narrower ranges
// - Output moves in whole converter steps
// - Empty input range jumps initial to final
// - Latch polarity selects freeze level or never
// - Freeze within 20 us, refresh within 100 us
// - Inversion polarity selects invert level or never
// - Inversion only on voltage outputs
package aos_pkg;
    localparam int AOS_N_OUT = 2;
    localparam int AOS_IDX_W = 1;
    localparam int AOS_CODE_STEPS = 16383;
    localparam logic [13:0] AOS_CODE_MAX = 14'(AOS_CODE_STEPS);
    localparam int AOS_SPAN_UNITS = 20000;
    localparam int AOS_VOLT_OFFS = 10000;
    localparam int AOS_NUM_W = 48;
    localparam int AOS_DEN_W = 33;
    localparam int AOS_CLK_NS = 10;
    localparam int AOS_FREEZE_NS = 20000;
    localparam int AOS_FREEZE_CYC = AOS_FREEZE_NS / AOS_CLK_NS;
    localparam int AOS_REFRESH_NS = 100000;
    localparam int AOS_REFRESH_CYC = AOS_REFRESH_NS / AOS_CLK_NS;
    localparam int AOS_DIV_MAX_CYC = 60;
    localparam logic [7:0] AOS_REG_CTRL = 8'h00;
    localparam logic [7:0] AOS_REG_STATUS = 8'h04;
    localparam logic [7:0] AOS_REG_CODE0 = 8'h08;
    localparam logic [7:0] AOS_REG_CODE1 = 8'h0c;
    localparam logic [3:0] AOS_CH_CFG = 4'h0;
    localparam logic [3:0] AOS_CH_INLO = 4'h4;
    localparam logic [3:0] AOS_CH_INHI = 4'h8;
    localparam logic [3:0] AOS_CH_ANLIM = 4'hc;
    localparam int AOS_CTRL_COUNT_LSB = 0;
    localparam int AOS_CTRL_LATCH_LSB = 2;
    localparam int AOS_CTRL_INV_LSB = 4;
    localparam logic [1:0] AOS_COUNT_RST = 2'h0;
    localparam logic [13:0] AOS_REFRESH_RST = 14'h0000;

    typedef enum logic [1:0] {
        AOS_POL_NEVER = 2'b00,
        AOS_LOW_INPUT_PASSES_SETTING = 2'b01,
        AOS_LOW_INPUT_ACTS_SETTING = 2'b10
    } aos_pol_t;

    typedef enum logic [1:0] {
        AOS_S_IDLE = 2'b00,
        AOS_S_CALC = 2'b01,
        AOS_S_DIV = 2'b11,
        AOS_S_STORE = 2'b10
    } aos_fsm_t;

    typedef struct packed {
        logic currentMode;
        logic useVelocity;
        logic signed [31:0] inLo;
        logic signed [31:0] inHi;
        logic signed [15:0] anLo;
        logic signed [15:0] anHi;
    } aos_chan_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } aos_avs_req_t;

    typedef struct packed {
        logic enable;
        logic currentMode;
        logic [13:0] code;
    } aos_dac_t;

    function automatic logic [13:0] aos_lim2code(input logic currentMode, input logic signed [15:0] v);
        int t;
        t = int'(v) + (currentMode ? 0 : AOS_VOLT_OFFS);
        if (t < 0) begin
            t = 0;
        end
        if (t > AOS_SPAN_UNITS) begin
            t = AOS_SPAN_UNITS;
        end
        return 14'((t * AOS_CODE_STEPS) / AOS_SPAN_UNITS);
    endfunction : aos_lim2code

    function automatic logic aos_pol_active(input aos_pol_t pol, input logic line);
        return (pol == AOS_LOW_INPUT_PASSES_SETTING) ? line :
               (pol == AOS_LOW_INPUT_ACTS_SETTING) ? !line : 1'b0;
    endfunction : aos_pol_active

    function automatic aos_pol_t aos_pol_decode(input logic [1:0] v);
        return (v == 2'b11) ? AOS_POL_NEVER : aos_pol_t'(v);
    endfunction : aos_pol_decode

    function automatic logic [31:0] aos_apply_be(input logic [31:0] old, input logic [31:0] wd,
                                                 input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : aos_apply_be
endpackage : aos_pkg

//--- aos_scaler.sv
// Purpose: Analog output scaler with latch and inversion control
// Assumes: position and velocity synchronous to clk_sys
// Notes: One shared divider serves outputs in turn
`timescale 1ns/1ps
module aos_scaler #(
    parameter int REFRESH_CYC = aos_pkg::AOS_REFRESH_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    // Register bus
    input aos_pkg::aos_avs_req_t avsReq,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Encoder values
    input wire logic signed [31:0] position,
    input wire logic signed [31:0] velocity,
    // User lines
    input wire logic latchLine,
    input wire logic invertLine,
    // Converter
    output aos_pkg::aos_dac_t [aos_pkg::AOS_N_OUT-1:0] dacOut
);
    import aos_pkg::*;

    typedef struct packed {
        logic [1:0] outCount;
        aos_pol_t latchPol;
        aos_pol_t invPol;
        aos_chan_t [AOS_N_OUT-1:0] chan;
        logic [AOS_N_OUT-1:0][13:0] dacCode;
        aos_fsm_t fsm;
        logic [AOS_IDX_W-1:0] idx;
        logic signed [31:0] xVal;
        logic [13:0] res;
        logic [13:0] codeLo;
        logic [13:0] codeHi;
        logic ack;
        logic [31:0] rdata;
        logic [13:0] refreshCnt;
    } aos_st_t;

    aos_st_t st_r;
    aos_st_t st_nxt;

    logic divStart;
    logic [AOS_NUM_W-1:0] divNum;
    logic [AOS_DEN_W-1:0] divDen;
    logic divDone;
    logic [AOS_NUM_W-1:0] divQuot;
    logic freezeAct;
    logic invAct;
    aos_chan_t curCh;
    logic signed [31:0] curX;
    logic [13:0] curLo;
    logic [13:0] curHi;
    logic [AOS_N_OUT-1:0] enVec;

    aos_divider u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .start(divStart),
        .num(divNum),
        .den(divDen),
        .done(divDone),
        .quot(divQuot)
    );

    assign freezeAct = aos_pol_active(st_r.latchPol, latchLine);
    assign invAct = aos_pol_active(st_r.invPol, invertLine);

    assign curCh = st_r.chan[st_r.idx];
    assign curX = curCh.useVelocity ? velocity : position;
    assign curLo = aos_lim2code(curCh.currentMode, curCh.anLo);
    assign curHi = aos_lim2code(curCh.currentMode, curCh.anHi);

    always_comb begin
        logic [31:0] rd;
        logic [31:0] word;
        logic [AOS_IDX_W-1:0] chSel;
        logic chHit;
        logic [32:0] diff;
        logic [1:0] nextIdx;
        logic [13:0] outCode;
        rd = '0;
        word = '0;
        chSel = '0;
        chHit = 1'b0;
        diff = '0;
        nextIdx = '0;
        outCode = '0;
        st_nxt = st_r;
        divStart = 1'b0;
        divNum = '0;
        divDen = '0;

        // Register decode
        chHit = (avsReq.address[7:4] >= 4'h1) && (avsReq.address[7:4] <= 4'(AOS_N_OUT));
        chSel = AOS_IDX_W'(avsReq.address[7:4] - 4'h1);
        if (chHit) begin
            unique case ({avsReq.address[3:2], 2'b00})
                AOS_CH_CFG: rd = {30'h0, st_r.chan[chSel].useVelocity, st_r.chan[chSel].currentMode};
                AOS_CH_INLO: rd = st_r.chan[chSel].inLo;
                AOS_CH_INHI: rd = st_r.chan[chSel].inHi;
                AOS_CH_ANLIM: rd = {st_r.chan[chSel].anHi, st_r.chan[chSel].anLo};
                default: rd = '0;
            endcase
        end else begin
            unique case ({avsReq.address[7:2], 2'b00})
                AOS_REG_CTRL: rd = {26'h0, st_r.invPol, st_r.latchPol, st_r.outCount};
                AOS_REG_STATUS: rd = {29'h0, (st_r.fsm != AOS_S_IDLE), invAct, freezeAct};
                AOS_REG_CODE0: rd = {18'h0, st_r.dacCode[0]};
                AOS_REG_CODE1: rd = {18'h0, st_r.dacCode[1]};
                default: rd = '0;
            endcase
        end

        // Bus handshake
        if ((avsReq.read || avsReq.write) && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.rdata = rd;
        end else if (st_r.ack) begin
            st_nxt.ack = 1'b0;
            if (avsReq.write && chHit) begin
                unique case ({avsReq.address[3:2], 2'b00})
                    AOS_CH_CFG: begin
                        word = aos_apply_be(rd, avsReq.writedata, avsReq.byteenable);
                        st_nxt.chan[chSel].currentMode = word[0];
                        st_nxt.chan[chSel].useVelocity = word[1];
                    end
                    AOS_CH_INLO: st_nxt.chan[chSel].inLo = aos_apply_be(rd, avsReq.writedata, avsReq.byteenable);
                    AOS_CH_INHI: st_nxt.chan[chSel].inHi = aos_apply_be(rd, avsReq.writedata, avsReq.byteenable);
                    AOS_CH_ANLIM: begin
                        word = aos_apply_be(rd, avsReq.writedata, avsReq.byteenable);
                        st_nxt.chan[chSel].anLo = word[15:0];
                        st_nxt.chan[chSel].anHi = word[31:16];
                    end
                    default: word = '0;
                endcase
            end else if (avsReq.write && ({avsReq.address[7:2], 2'b00} == AOS_REG_CTRL)) begin
                word = aos_apply_be(rd, avsReq.writedata, avsReq.byteenable);
                st_nxt.outCount = word[AOS_CTRL_COUNT_LSB +: 2];
                st_nxt.latchPol = aos_pol_decode(word[AOS_CTRL_LATCH_LSB +: 2]);
                st_nxt.invPol = aos_pol_decode(word[AOS_CTRL_INV_LSB +: 2]);
            end
        end

        // Conversion sequencer
        unique case (st_r.fsm)
            AOS_S_IDLE: begin
                st_nxt.idx = '0;
                if (st_r.outCount != 2'h0) begin
                    st_nxt.fsm = AOS_S_CALC;
                end
            end
            AOS_S_CALC: begin
                st_nxt.xVal = curX;
                st_nxt.codeLo = curLo;
                st_nxt.codeHi = curHi;
                if (curX >= curCh.inHi) begin
                    st_nxt.res = curHi;
                    st_nxt.fsm = AOS_S_STORE;
                end else if (curX <= curCh.inLo) begin
                    st_nxt.res = curLo;
                    st_nxt.fsm = AOS_S_STORE;
                end else begin
                    diff = 33'({curX[31], curX} - {curCh.inLo[31], curCh.inLo});
                    divNum = AOS_NUM_W'(diff) * AOS_NUM_W'(curHi - curLo);
                    divDen = 33'({curCh.inHi[31], curCh.inHi} - {curCh.inLo[31], curCh.inLo});
                    divStart = 1'b1;
                    st_nxt.fsm = AOS_S_DIV;
                end
            end
            AOS_S_DIV: begin
                if (divDone) begin
                    st_nxt.res = st_r.codeLo + divQuot[13:0];
                    st_nxt.fsm = AOS_S_STORE;
                end
            end
            AOS_S_STORE: begin
                outCode = (invAct && !st_r.chan[st_r.idx].currentMode) ? (AOS_CODE_MAX - st_r.res) : st_r.res;
                if (!freezeAct) begin
                    st_nxt.dacCode[st_r.idx] = outCode;
                end
                nextIdx = {1'b0, st_r.idx} + 2'h1;
                if (st_r.outCount == 2'h0) begin
                    st_nxt.fsm = AOS_S_IDLE;
                end else begin
                    st_nxt.idx = (nextIdx >= st_r.outCount) ? '0 : AOS_IDX_W'(nextIdx);
                    st_nxt.fsm = AOS_S_CALC;
                end
            end
        endcase

        // Refresh age
        if (freezeAct || (st_r.outCount == 2'h0) || (st_r.fsm == AOS_S_STORE)) begin
            st_nxt.refreshCnt = AOS_REFRESH_RST;
        end else if (st_r.refreshCnt != 14'h3fff) begin
            st_nxt.refreshCnt = st_r.refreshCnt + 14'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.outCount <= AOS_COUNT_RST;
            st_r.latchPol <= AOS_POL_NEVER;
            st_r.invPol <= AOS_POL_NEVER;
            st_r.fsm <= AOS_S_IDLE;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign avsReadData = st_r.rdata;
    assign avsWaitRequest = (avsReq.read || avsReq.write) && !st_r.ack;

    always_comb begin
        for (int i = 0; i < AOS_N_OUT; i++) begin
            enVec[i] = (2'(i) < st_r.outCount);
            dacOut[i].enable = enVec[i];
            dacOut[i].currentMode = st_r.chan[i].currentMode;
            dacOut[i].code = st_r.dacCode[i];
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || !clkEn);

    sequence s_divGo;
        (st_r.fsm == AOS_S_CALC) && divStart;
    endsequence

    sequence s_divBack;
        (st_r.fsm == AOS_S_DIV) && divDone;
    endsequence

    property p_count_off;
        (st_r.outCount == 2'h0) |-> (enVec == '0);
    endproperty
    a_count_off: assert property (p_count_off) else $error("output enabled with zero count");

    property p_chan_select;
        (st_r.fsm == AOS_S_CALC) |=> (st_r.xVal == ($past(curCh.useVelocity) ? $past(velocity) : $past(position)));
    endproperty
    a_chan_select: assert property (p_chan_select) else $error("wrong input quantity");

    property p_full_scale;
        (st_r.fsm == AOS_S_CALC) && !curCh.currentMode && (curCh.anLo == -16'sd10000)
            |=> (st_r.codeLo == 14'h0000);
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("voltage low end not code zero");

    property p_clamp_hi;
        (st_r.fsm == AOS_S_CALC) && (curX >= curCh.inHi) |=> (st_r.res == st_r.codeHi) && (st_r.fsm == AOS_S_STORE);
    endproperty
    a_clamp_hi: assert property (p_clamp_hi) else $error("high clamp missed");

    property p_clamp_lo;
        (st_r.fsm == AOS_S_CALC) && (curX <= curCh.inLo) && (curX < curCh.inHi)
            |=> (st_r.res == st_r.codeLo) && (st_r.fsm == AOS_S_STORE);
    endproperty
    a_clamp_lo: assert property (p_clamp_lo) else $error("low clamp missed");

    property p_div_turn;
        s_divGo |-> ##[1:60] s_divBack;
    endproperty
    a_div_turn: assert property (p_div_turn) else $error("division did not finish");

    property p_linear_bounds;
        s_divBack |=> (st_r.res >= st_r.codeLo) && (st_r.res <= st_r.codeHi);
    endproperty
    a_linear_bounds: assert property (p_linear_bounds) else $error("linear result out of range");

    property p_freeze_stop;
        freezeAct |=> $stable(st_r.dacCode);
    endproperty
    a_freeze_stop: assert property (p_freeze_stop) else $error("code changed while frozen");

    property p_refresh_bound;
        int'(st_r.refreshCnt) < REFRESH_CYC;
    endproperty
    a_refresh_bound: assert property (p_refresh_bound) else $error("refresh too late");

    property p_invert;
        (st_r.fsm == AOS_S_STORE) && !freezeAct && invAct && !st_r.chan[st_r.idx].currentMode
            |=> (st_r.dacCode[$past(st_r.idx)] == (AOS_CODE_MAX - $past(st_r.res)));
    endproperty
    a_invert: assert property (p_invert) else $error("voltage output not inverted");

    property p_no_cur_invert;
        (st_r.fsm == AOS_S_STORE) && !freezeAct && st_r.chan[st_r.idx].currentMode
            |=> (st_r.dacCode[$past(st_r.idx)] == $past(st_r.res));
    endproperty
    a_no_cur_invert: assert property (p_no_cur_invert) else $error("current output altered");
endmodule : aos_scaler

//--- aos_user_model.sv
// Purpose: User-side model of the latch and inversion lines
// Assumes: Bench asks for freeze as a plain request and drives the inversion line level directly
// Notes: readOk rises after freeze time plus own line delay
`timescale 1ns/1ps
module aos_user_model #(
    parameter int OWN_DELAY_CYC = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bench requests
    input wire logic freezeReq,
    input wire logic invertReq,
    input aos_pkg::aos_pol_t latchPol,
    // Lines to the scaler
    output logic latchLine,
    output logic invertLine,
    // Reading side
    output logic readOk
);
    import aos_pkg::*;
    int waitCnt;
    assign latchLine = (latchPol == AOS_LOW_INPUT_ACTS_SETTING) ? !freezeReq : freezeReq;
    assign invertLine = invertReq;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waitCnt <= 0;
            readOk <= 1'b0;
        end else if (!freezeReq) begin
            waitCnt <= 0;
            readOk <= 1'b0;
        end else if (waitCnt < AOS_FREEZE_CYC + OWN_DELAY_CYC) begin
            waitCnt <= waitCnt + 1;
        end else begin
            readOk <= 1'b1;
        end
    end
endmodule : aos_user_model
